//--- core/ctp_pkg.sv
// Package for the cascadable timer pair: register map, field layout, constants
package ctp_pkg;
	localparam int unsigned CTP_ADDR_W = 4;
	localparam int unsigned CTP_DATA_W = 16;

	// Register word offsets
	localparam logic [3:0] CTP_OFF_LO_CTRL   = 4'h0;
	localparam logic [3:0] CTP_OFF_HI_CTRL   = 4'h1;
	localparam logic [3:0] CTP_OFF_LO_COUNT  = 4'h2;
	localparam logic [3:0] CTP_OFF_HI_COUNT  = 4'h3;
	localparam logic [3:0] CTP_OFF_LO_PERIOD = 4'h4;
	localparam logic [3:0] CTP_OFF_HI_PERIOD = 4'h5;
	localparam logic [3:0] CTP_OFF_IRQ_STAT  = 4'h6;
	localparam logic [3:0] CTP_OFF_IRQ_MASK  = 4'h7;

	// Control field positions
	localparam int unsigned CTP_B_RUN     = 15;
	localparam int unsigned CTP_B_SIDL    = 13;
	localparam int unsigned CTP_B_GATE    = 6;
	localparam int unsigned CTP_B_PS_HI   = 5;
	localparam int unsigned CTP_B_PS_LO   = 4;
	localparam int unsigned CTP_B_CASCADE = 3;
	localparam int unsigned CTP_B_CSRC    = 1;

	// Implemented bit masks
	localparam logic [15:0] CTP_LO_CTRL_MASK = 16'ha07a;
	localparam logic [15:0] CTP_HI_CTRL_MASK = 16'ha072;
	localparam logic [15:0] CTP_CTRL_RESET   = 16'h0000;
	localparam logic [15:0] CTP_PERIOD_RESET = 16'hffff;

	// Interrupt status bits
	localparam int unsigned CTP_IRQ_LO = 0;
	localparam int unsigned CTP_IRQ_HI = 1;
	localparam int unsigned CTP_IRQ_W  = 2;

	// Prescale codes and terminal counts
	localparam logic [1:0] CTP_PS_1   = 2'h0;
	localparam logic [1:0] CTP_PS_8   = 2'h1;
	localparam logic [1:0] CTP_PS_64  = 2'h2;
	localparam logic [1:0] CTP_PS_256 = 2'h3;
	localparam logic [7:0] CTP_PS_TC_1   = 8'h00;
	localparam logic [7:0] CTP_PS_TC_8   = 8'h07;
	localparam logic [7:0] CTP_PS_TC_64  = 8'h3f;
	localparam logic [7:0] CTP_PS_TC_256 = 8'hff;

	// Control fields decoded for one timer
	typedef struct packed {
		logic       run;
		logic       sidl;
		logic       gate;
		logic [1:0] ps;
		logic       csrc;
	} ctp_ctrl_t;
endpackage

//--- core/ctp_prescaler.sv
// Prescaler: divides a tick stream by 1, 8, 64 or 256
`timescale 1ns/1ps
module ctp_prescaler
	import ctp_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// Control
	input  wire logic       clr,
	input  wire logic [1:0] ps,
	// Ticks
	input  wire logic       tick_in,
	output logic            tick_out
);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic [7:0] tc;

	always_comb begin
		unique case (ps)
			CTP_PS_1:   tc = CTP_PS_TC_1;
			CTP_PS_8:   tc = CTP_PS_TC_8;
			CTP_PS_64:  tc = CTP_PS_TC_64;
			CTP_PS_256: tc = CTP_PS_TC_256;
		endcase
		cnt_nxt  = cnt_r;
		tick_out = 1'b0;
		if (clr) begin
			cnt_nxt = 8'h00;
		end else if (tick_in) begin
			if (cnt_r >= tc) begin
				cnt_nxt  = 8'h00;
				tick_out = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule

//--- core/ctp_sync.sv
// Two-flop synchroniser with rising-edge pulse
`timescale 1ns/1ps
module ctp_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// Level in, synced level and rise pulse out
	input  wire logic din,
	output logic      dout,
	output logic      rise
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign dout = s2_r;
	assign rise = s2_r & ~s3_r;
endmodule

//--- core/ctp_timer_pair.sv
// Cascadable pair of 16-bit timers with register port and interrupt
//
// Summary of operation
// - Lower run bit starts/stops the 32-bit pair if cascaded, else lower timer.
// - Stop-in-idle set halts the timer in idle; clear keeps it counting.
// - Gating bit is ignored when the external clock source is selected.
// - Internal clock with gating set gives gated accumulation, else plain counting.
// - Prescale code 11/10/01/00 divides input ticks by 256/64/8/1.
// - Cascade bit 3 of lower control joins both timers into one 32-bit timer.
// - Clock-source bit selects external pin when set, internal half clock when clear.
// - In cascade, upper run, gate, prescale and source bits have no effect.
// - In cascade, the pair halts in idle only if upper stop-in-idle is set.
// - Unimplemented control bits ignore writes and read as zero.
// - Upper timer holds high count and period words, lower holds low words.
// - In cascade, interrupt comes from the upper timer; lower flag is ignored.
// - Lower timer synchronises its external clock after its prescaler.
// - Upper timer synchronises its external clock before its prescaler.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module ctp_timer_pair
	import ctp_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	// Register port
	input  wire logic [CTP_ADDR_W-1:0] reg_addr,
	input  wire logic [CTP_DATA_W-1:0] reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [CTP_DATA_W-1:0] reg_rdata,
	// Device state and pins
	input  wire logic                  idle_mode,
	input  wire logic                  lo_ext_clk,
	input  wire logic                  hi_ext_clk,
	input  wire logic                  lo_gate,
	input  wire logic                  hi_gate,
	// Interrupt
	output logic                       irq
);
	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [15:0] lo_ctrl_r, lo_ctrl_nxt, hi_ctrl_r, hi_ctrl_nxt;
	logic [15:0] lo_per_r, lo_per_nxt, hi_per_r, hi_per_nxt;
	logic [15:0] lo_cnt_r, lo_cnt_nxt, hi_cnt_r, hi_cnt_nxt;
	logic [CTP_IRQ_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic        irq_r, irq_nxt;
	logic        half_r, lo_gate_d_r, hi_gate_d_r;
	logic        lo_half_r;
	ctp_ctrl_t   lo_c, hi_c;
	logic        cascade;

	always_comb begin
		lo_c = '{run: lo_ctrl_r[CTP_B_RUN], sidl: lo_ctrl_r[CTP_B_SIDL], gate: lo_ctrl_r[CTP_B_GATE],
			ps: lo_ctrl_r[CTP_B_PS_HI:CTP_B_PS_LO], csrc: lo_ctrl_r[CTP_B_CSRC]};
		hi_c = '{run: hi_ctrl_r[CTP_B_RUN], sidl: hi_ctrl_r[CTP_B_SIDL], gate: hi_ctrl_r[CTP_B_GATE],
			ps: hi_ctrl_r[CTP_B_PS_HI:CTP_B_PS_LO], csrc: hi_ctrl_r[CTP_B_CSRC]};
	end
	assign cascade = lo_ctrl_r[CTP_B_CASCADE];

	////////////////////////////////////////////////////////////////////////
	// Tick sources
	logic lo_ext_s, hi_ext_rise;
	logic lo_raw, hi_raw, lo_pre, hi_pre;
	logic lo_active, hi_active, pair_active;
	logic lo_gating, hi_gating;

	// Lower pin is prescaled first, then synchronised
	ctp_sync u_lo_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.din     (lo_half_r),
		.dout    (lo_ext_s),
		.rise    ()
	);
	// Upper pin is synchronised first, then prescaled
	ctp_sync u_hi_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.din     (hi_ext_clk),
		.dout    (),
		.rise    (hi_ext_rise)
	);

	// Simple edge-count prescale for the raw lower pin, toggled per divided edge
	logic [7:0] lo_pin_cnt_r, lo_pin_cnt_nxt;
	logic       lo_pin_d_r, lo_half_nxt, lo_pin_rise;
	logic [7:0] lo_tc;
	assign lo_pin_rise = lo_ext_clk & ~lo_pin_d_r;
	always_comb begin
		unique case (lo_c.ps)
			CTP_PS_1:   lo_tc = CTP_PS_TC_1;
			CTP_PS_8:   lo_tc = CTP_PS_TC_8;
			CTP_PS_64:  lo_tc = CTP_PS_TC_64;
			CTP_PS_256: lo_tc = CTP_PS_TC_256;
		endcase
		lo_pin_cnt_nxt = lo_pin_cnt_r;
		lo_half_nxt    = lo_half_r;
		if (lo_pin_rise) begin
			if (lo_pin_cnt_r >= lo_tc) begin
				lo_pin_cnt_nxt = 8'h00;
				lo_half_nxt    = ~lo_half_r;
			end else begin
				lo_pin_cnt_nxt = lo_pin_cnt_r + 8'h01;
			end
		end
	end
	// Toggle output: each change is one prescaled edge
	logic lo_ext_s_d_r, lo_pin_tick;
	assign lo_pin_tick = lo_ext_s ^ lo_ext_s_d_r;

	// Internal clock at half the device clock
	assign lo_active   = lo_c.run & ~(idle_mode & lo_c.sidl);
	assign hi_active   = hi_c.run & ~(idle_mode & hi_c.sidl);
	assign pair_active = lo_c.run & ~(idle_mode & hi_c.sidl);
	assign lo_gating   = ~lo_c.csrc & lo_c.gate;
	assign hi_gating   = ~hi_c.csrc & hi_c.gate;

	always_comb begin
		if (lo_c.csrc) begin
			lo_raw = 1'b0;
		end else begin
			lo_raw = half_r & (~lo_gating | lo_gate);
		end
		if (hi_c.csrc) begin
			hi_raw = hi_ext_rise;
		end else begin
			hi_raw = half_r & (~hi_gating | hi_gate);
		end
	end

	logic lo_int_pre;
	ctp_prescaler u_lo_ps (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.clr      (~lo_c.run),
		.ps       (lo_c.ps),
		.tick_in  (lo_raw),
		.tick_out (lo_int_pre)
	);
	ctp_prescaler u_hi_ps (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.clr      (~hi_c.run | cascade),
		.ps       (hi_c.ps),
		.tick_in  (hi_raw),
		.tick_out (hi_pre)
	);
	assign lo_pre = lo_c.csrc ? lo_pin_tick : lo_int_pre;

	////////////////////////////////////////////////////////////////////////
	// Counters, register port, interrupt
	logic lo_match, hi_match, pair_match, lo_tick, hi_tick;
	logic lo_gfall, hi_gfall, lo_ev, hi_ev;
	assign lo_match   = (lo_cnt_r == lo_per_r);
	assign hi_match   = (hi_cnt_r == hi_per_r);
	assign pair_match = lo_match & hi_match;
	assign lo_tick    = lo_pre & (cascade ? pair_active : lo_active);
	assign hi_tick    = hi_pre & hi_active & ~cascade;
	assign lo_gfall   = lo_gating & lo_gate_d_r & ~lo_gate;
	assign hi_gfall   = hi_gating & hi_gate_d_r & ~hi_gate;

	always_comb begin
		lo_cnt_nxt = lo_cnt_r;
		hi_cnt_nxt = hi_cnt_r;
		lo_ev      = 1'b0;
		hi_ev      = 1'b0;
		if (cascade) begin
			if (lo_tick) begin
				if (pair_match) begin
					lo_cnt_nxt = 16'h0000;
					hi_cnt_nxt = 16'h0000;
					hi_ev      = ~lo_gating;
				end else begin
					{hi_cnt_nxt, lo_cnt_nxt} = {hi_cnt_r, lo_cnt_r} + 32'h0000_0001;
				end
			end
			hi_ev = hi_ev | (lo_gfall & lo_c.run);
		end else begin
			if (lo_tick) begin
				lo_cnt_nxt = lo_match ? 16'h0000 : lo_cnt_r + 16'h0001;
				lo_ev      = lo_match & ~lo_gating;
			end
			if (hi_tick) begin
				hi_cnt_nxt = hi_match ? 16'h0000 : hi_cnt_r + 16'h0001;
				hi_ev      = hi_match & ~hi_gating;
			end
			lo_ev = lo_ev | (lo_gfall & lo_c.run);
			hi_ev = hi_ev | (hi_gfall & hi_c.run);
		end
		lo_ctrl_nxt = lo_ctrl_r;
		hi_ctrl_nxt = hi_ctrl_r;
		lo_per_nxt  = lo_per_r;
		hi_per_nxt  = hi_per_r;
		mask_nxt    = mask_r;
		stat_nxt    = stat_r;
		if (reg_wr) begin
			unique case (reg_addr)
				CTP_OFF_LO_CTRL:   lo_ctrl_nxt = reg_wdata & CTP_LO_CTRL_MASK;
				CTP_OFF_HI_CTRL:   hi_ctrl_nxt = reg_wdata & CTP_HI_CTRL_MASK;
				CTP_OFF_LO_COUNT:  lo_cnt_nxt  = reg_wdata;
				CTP_OFF_HI_COUNT:  hi_cnt_nxt  = reg_wdata;
				CTP_OFF_LO_PERIOD: lo_per_nxt  = reg_wdata;
				CTP_OFF_HI_PERIOD: hi_per_nxt  = reg_wdata;
				CTP_OFF_IRQ_STAT:  stat_nxt    = stat_r & ~reg_wdata[CTP_IRQ_W-1:0];
				CTP_OFF_IRQ_MASK:  mask_nxt    = reg_wdata[CTP_IRQ_W-1:0];
				default:           ;
			endcase
		end
		// Set wins over clear
		stat_nxt[CTP_IRQ_LO] = stat_nxt[CTP_IRQ_LO] | lo_ev;
		stat_nxt[CTP_IRQ_HI] = stat_nxt[CTP_IRQ_HI] | hi_ev;
		irq_nxt = |(stat_nxt & mask_nxt & (cascade ? 2'b10 : 2'b11));
		rdata_nxt = 16'h0000;
		if (reg_rd) begin
			unique case (reg_addr)
				CTP_OFF_LO_CTRL:   rdata_nxt = lo_ctrl_r;
				CTP_OFF_HI_CTRL:   rdata_nxt = hi_ctrl_r;
				CTP_OFF_LO_COUNT:  rdata_nxt = lo_cnt_r;
				CTP_OFF_HI_COUNT:  rdata_nxt = hi_cnt_r;
				CTP_OFF_LO_PERIOD: rdata_nxt = lo_per_r;
				CTP_OFF_HI_PERIOD: rdata_nxt = hi_per_r;
				CTP_OFF_IRQ_STAT:  rdata_nxt = {14'h0000, stat_r};
				CTP_OFF_IRQ_MASK:  rdata_nxt = {14'h0000, mask_r};
				default:           rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lo_ctrl_r    <= CTP_CTRL_RESET;
			hi_ctrl_r    <= CTP_CTRL_RESET;
			lo_per_r     <= CTP_PERIOD_RESET;
			hi_per_r     <= CTP_PERIOD_RESET;
			lo_cnt_r     <= 16'h0000;
			hi_cnt_r     <= 16'h0000;
			stat_r       <= '0;
			mask_r       <= '0;
			rdata_r      <= 16'h0000;
			irq_r        <= 1'b0;
			half_r       <= 1'b0;
			lo_gate_d_r  <= 1'b0;
			hi_gate_d_r  <= 1'b0;
			lo_pin_cnt_r <= 8'h00;
			lo_pin_d_r   <= 1'b0;
			lo_half_r    <= 1'b0;
			lo_ext_s_d_r <= 1'b0;
		end else begin
			lo_ctrl_r    <= lo_ctrl_nxt;
			hi_ctrl_r    <= hi_ctrl_nxt;
			lo_per_r     <= lo_per_nxt;
			hi_per_r     <= hi_per_nxt;
			lo_cnt_r     <= lo_cnt_nxt;
			hi_cnt_r     <= hi_cnt_nxt;
			stat_r       <= stat_nxt;
			mask_r       <= mask_nxt;
			rdata_r      <= rdata_nxt;
			irq_r        <= irq_nxt;
			half_r       <= ~half_r;
			lo_gate_d_r  <= lo_gate;
			hi_gate_d_r  <= hi_gate;
			lo_pin_cnt_r <= lo_pin_cnt_nxt;
			lo_pin_d_r   <= lo_ext_clk;
			lo_half_r    <= lo_half_nxt;
			lo_ext_s_d_r <= lo_ext_s;
		end
	end

	assign reg_rdata = rdata_r;
	assign irq       = irq_r;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	a_ctrl_unimpl_zero: assert property (@(posedge clk) disable iff (sys_rst)
		((lo_ctrl_r & ~CTP_LO_CTRL_MASK) == 16'h0000) && ((hi_ctrl_r & ~CTP_HI_CTRL_MASK) == 16'h0000))
		else $error("Unimplemented control bit set");
	a_stopped_holds: assert property (@(posedge clk) disable iff (sys_rst)
		(!lo_c.run && !reg_wr) |=> $stable(lo_cnt_r))
		else $error("Lower counter moved while stopped");
	a_idle_halts: assert property (@(posedge clk) disable iff (sys_rst)
		(!cascade && idle_mode && hi_c.sidl && !reg_wr) |=> $stable(hi_cnt_r))
		else $error("Upper counter moved in idle");
	a_cascade_idle: assert property (@(posedge clk) disable iff (sys_rst)
		(cascade && idle_mode && hi_c.sidl && !reg_wr) |=> $stable(lo_cnt_r))
		else $error("Pair counted in idle");
	a_upper_ignored: assert property (@(posedge clk) disable iff (sys_rst)
		(cascade && !lo_c.run && !reg_wr) |=> $stable(hi_cnt_r))
		else $error("Upper word moved with pair stopped");
	a_wrap_zero: assert property (@(posedge clk) disable iff (sys_rst)
		(!cascade && lo_tick && lo_match && !reg_wr) |=> (lo_cnt_r == 16'h0000))
		else $error("Lower counter did not wrap");
	a_wrap_flag: assert property (@(posedge clk) disable iff (sys_rst)
		(!cascade && lo_tick && lo_match && !lo_gating) |=> stat_r[CTP_IRQ_LO])
		else $error("Lower flag not set at wrap");
	a_gate_fall: assert property (@(posedge clk) disable iff (sys_rst)
		(!cascade && lo_gfall && lo_c.run) |=> stat_r[CTP_IRQ_LO])
		else $error("Gate fall did not flag");
	a_cascade_irq: assert property (@(posedge clk) disable iff (sys_rst)
		(cascade && !stat_r[CTP_IRQ_HI]) |=> !irq_r || stat_r[CTP_IRQ_HI])
		else $error("Lower flag raised cascaded irq");
	a_ext_ignores_gate: assert property (@(posedge clk) disable iff (sys_rst)
		hi_c.csrc |-> (hi_raw == hi_ext_rise))
		else $error("Gate affected external clock");
	c_cascade_wrap: cover property (@(posedge clk) disable iff (sys_rst) cascade && lo_tick && pair_match);
	c_lo_wrap: cover property (@(posedge clk) disable iff (sys_rst) !cascade && lo_tick && lo_match);
	c_gate_fall: cover property (@(posedge clk) disable iff (sys_rst) lo_gfall && lo_c.run);
	c_irq: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq_r));
endmodule

//--- tb/ctp_timer_pair_tb.sv
// Self-checking testbench for the cascadable timer pair
`timescale 1ns/1ps
module ctp_timer_pair_tb;
	import ctp_pkg::*;

	localparam logic [15:0] K_RUN  = 16'h8000;
	localparam logic [15:0] K_SIDL = 16'h2000;
	localparam logic [15:0] K_GATE = 16'h0040;
	localparam logic [15:0] K_CAS  = 16'h0008;
	localparam logic [15:0] K_CSRC = 16'h0002;
	localparam int          LIMIT  = 40000;

	logic                  clk;
	logic                  sys_rst;
	logic [CTP_ADDR_W-1:0] reg_addr;
	logic [CTP_DATA_W-1:0] reg_wdata;
	logic                  reg_wr;
	logic                  reg_rd;
	logic [CTP_DATA_W-1:0] reg_rdata;
	logic                  idle_mode;
	logic                  lo_ext_clk;
	logic                  hi_ext_clk;
	logic                  lo_gate;
	logic                  hi_gate;
	logic                  irq;
	int                    fails;
	int                    total_checks;
	int                    cycles;
	logic [15:0]           d;
	int                    div_tab [4] = '{1, 8, 64, 256};
	logic [15:0]           rst_tab [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'hffff,
		16'h0000, 16'h0000, 16'h0000};

	ctp_timer_pair u_dut (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata),
		.idle_mode (idle_mode),
		.lo_ext_clk(lo_ext_clk),
		.hi_ext_clk(hi_ext_clk),
		.lo_gate   (lo_gate),
		.hi_gate   (hi_gate),
		.irq       (irq)
	);

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fails = fails + 1;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic rng(input logic [3:0] a, input int lo, input int hi);
		rd(a);
		check({15'h0000, (d >= lo[15:0] && d <= hi[15:0])}, 16'h0001);
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic pulses(input bit upper, input int n);
		repeat (n) begin
			@(posedge clk);
			if (upper) hi_ext_clk <= 1'b1; else lo_ext_clk <= 1'b1;
			waitc(4);
			if (upper) hi_ext_clk <= 1'b0; else lo_ext_clk <= 1'b0;
			waitc(3);
		end
	endtask

	task automatic restart(input logic [15:0] lo_ctl, input logic [15:0] hi_ctl);
		wr(CTP_OFF_LO_COUNT, 16'h0000);
		wr(CTP_OFF_HI_COUNT, 16'h0000);
		wr(CTP_OFF_HI_CTRL, hi_ctl);
		wr(CTP_OFF_LO_CTRL, lo_ctl);
	endtask

	task automatic stop_all();
		wr(CTP_OFF_LO_CTRL, 16'h0000);
		wr(CTP_OFF_HI_CTRL, 16'h0000);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_rst = 1'b1; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0;
		idle_mode = 1'b0; lo_ext_clk = 1'b0; hi_ext_clk = 1'b0; lo_gate = 1'b0; hi_gate = 1'b0;
		fails = 0; total_checks = 0; cycles = 0;
		waitc(8);
		sys_rst <= 1'b0;
		// Reset values, unmapped index, unimplemented bits
		for (int i = 0; i < 9; i++) begin
			rd(i[3:0]);
			check(d, rst_tab[i]);
		end
		check({15'h0000, irq}, 16'h0000);
		wr(4'h9, 16'hffff);
		rd(4'h9);
		check(d, 16'h0000);
		wr(CTP_OFF_LO_CTRL, 16'hffff);
		wr(CTP_OFF_HI_CTRL, 16'hffff);
		rd(CTP_OFF_LO_CTRL);
		check(d, 16'ha07a);
		rd(CTP_OFF_HI_CTRL);
		check(d, 16'ha072);
		stop_all();
		$display("test registers done");
		// Every prescale code, eight ticks per window
		for (int i = 0; i < 4; i++) begin
			restart(K_RUN | (16'(i) << 4), 16'h0000);
			waitc(16 * div_tab[i]);
			stop_all();
			rng(CTP_OFF_LO_COUNT, 7, 9);
			rd(CTP_OFF_LO_COUNT);
			rng(CTP_OFF_LO_COUNT, d, d);
		end
		$display("test prescale done");
		// Period wrap, flag, mask and clear
		wr(CTP_OFF_LO_PERIOD, 16'h0003);
		restart(K_RUN, 16'h0000);
		waitc(40);
		stop_all();
		rng(CTP_OFF_LO_COUNT, 0, 3);
		rd(CTP_OFF_IRQ_STAT);
		check(d, 16'h0001);
		check({15'h0000, irq}, 16'h0000);
		wr(CTP_OFF_IRQ_MASK, 16'h0001);
		#1 check({15'h0000, irq}, 16'h0001);
		wr(CTP_OFF_IRQ_STAT, 16'h0001);
		#1 check({15'h0000, irq}, 16'h0000);
		$display("test period done");
		// Cascade carry, upper controls ignored
		wr(CTP_OFF_LO_PERIOD, 16'hffff);
		wr(CTP_OFF_HI_PERIOD, 16'h0001);
		restart(16'h0000, K_RUN | K_CSRC | 16'h0030);
		wr(CTP_OFF_LO_COUNT, 16'hfff0);
		wr(CTP_OFF_LO_CTRL, K_RUN | K_CAS);
		waitc(40);
		stop_all();
		rd(CTP_OFF_HI_COUNT);
		check(d, 16'h0001);
		rng(CTP_OFF_LO_COUNT, 3, 5);
		// Cascade interrupt comes from upper flag
		wr(CTP_OFF_LO_PERIOD, 16'h0005);
		wr(CTP_OFF_HI_PERIOD, 16'h0000);
		restart(K_RUN | K_CAS, 16'h0000);
		waitc(40);
		stop_all();
		rd(CTP_OFF_IRQ_STAT);
		check(d, 16'h0002);
		#1 check({15'h0000, irq}, 16'h0000);
		wr(CTP_OFF_IRQ_MASK, 16'h0002);
		#1 check({15'h0000, irq}, 16'h0001);
		wr(CTP_OFF_IRQ_STAT, 16'h0003);
		wr(CTP_OFF_IRQ_MASK, 16'h0000);
		wr(CTP_OFF_LO_PERIOD, 16'hffff);
		wr(CTP_OFF_HI_PERIOD, 16'hffff);
		$display("test cascade done");
		// Idle behaviour, single and cascaded
		idle_mode <= 1'b1;
		restart(K_RUN | K_SIDL, 16'h0000);
		waitc(40);
		stop_all();
		rng(CTP_OFF_LO_COUNT, 0, 0);
		restart(K_RUN, 16'h0000);
		waitc(40);
		stop_all();
		rng(CTP_OFF_LO_COUNT, 18, 22);
		restart(16'h0000, K_RUN | K_SIDL);
		waitc(40);
		stop_all();
		rng(CTP_OFF_HI_COUNT, 0, 0);
		restart(K_RUN | K_CAS, K_SIDL);
		waitc(40);
		stop_all();
		rng(CTP_OFF_LO_COUNT, 0, 0);
		restart(K_RUN | K_CAS | K_SIDL, 16'h0000);
		waitc(40);
		stop_all();
		rng(CTP_OFF_LO_COUNT, 18, 22);
		idle_mode <= 1'b0;
		$display("test idle done");
		// External clocks, gate bit ignored
		restart(K_RUN | K_CSRC | K_GATE, 16'h0000);
		pulses(1'b0, 6);
		waitc(6);
		stop_all();
		rng(CTP_OFF_LO_COUNT, 5, 6);
		restart(16'h0000, K_RUN | K_CSRC);
		pulses(1'b1, 6);
		waitc(6);
		stop_all();
		rng(CTP_OFF_HI_COUNT, 5, 6);
		$display("test external done");
		// Gated accumulation and falling-edge flag
		wr(CTP_OFF_IRQ_STAT, 16'h0003);
		restart(K_RUN | K_GATE, 16'h0000);
		waitc(20);
		rng(CTP_OFF_LO_COUNT, 0, 0);
		lo_gate <= 1'b1;
		waitc(40);
		lo_gate <= 1'b0;
		waitc(8);
		stop_all();
		rng(CTP_OFF_LO_COUNT, 18, 22);
		rd(CTP_OFF_IRQ_STAT);
		check(d, 16'h0001);
		$display("test gated done");
		report_and_stop();
	end
endmodule
